// File: core/rffs_regulator_fault_flags.sv
/*
  Per-phase sticky event flags and live status bits of a four-phase
  step-down regulator, read and cleared over the internal register port.
  Assumes the sensed analog conditions arrive asynchronously and that the
  mask bits come from the neighbouring mask registers on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module rffs_regulator_fault_flags #(
  parameter int unsigned P_SC_START_CYCLES = rffs_pkg::SC_START_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire rffs_pkg::rffs_sense_t i_sense,
  input wire logic [7:0] i_mask01,
  input wire logic [7:0] i_mask23,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic [3:0] o_pending,
  output logic o_irq
);

  // ******************************
  // input synchronisers
  // ******************************
  rffs_pkg::rffs_sense_t sense_meta;
  rffs_pkg::rffs_sense_t sense_sync;
  rffs_pkg::rffs_sense_t sense_prev;

  // meta is read only by sync; edges are taken from sync against prev
  always_ff @(posedge i_clk_sys) begin
    sense_meta <= i_sense;
    sense_sync <= sense_meta;
    sense_prev <= sense_sync;
  end

  // ******************************
  // short-circuit supervision
  // ******************************
  rffs_pkg::rffs_sc_state_t sc_state;
  rffs_pkg::rffs_sc_state_t next_sc_state;
  logic [rffs_pkg::SC_CNT_W-1:0] sc_cnt;
  logic [rffs_pkg::SC_CNT_W-1:0] next_sc_cnt;
  logic sc_set;
  localparam logic [rffs_pkg::SC_CNT_W-1:0] SC_LAST =
    rffs_pkg::SC_CNT_W'(P_SC_START_CYCLES - 1);

  always_comb begin
    next_sc_state = sc_state;
    next_sc_cnt = sc_cnt;
    sc_set = 1'b0;
    case (sc_state)
      rffs_pkg::RFFS_SC_OFF: begin
        next_sc_cnt = '0;
        if (sense_sync.phase0_en) begin
          next_sc_state = rffs_pkg::RFFS_SC_START;
        end
      end
      rffs_pkg::RFFS_SC_START: begin
        next_sc_cnt = sc_cnt + 1'b1;
        if (!sense_sync.phase0_en) begin
          next_sc_state = rffs_pkg::RFFS_SC_OFF;
        end else if (sense_sync.phase0_above_short) begin
          next_sc_state = rffs_pkg::RFFS_SC_RUN;
        end else if (sc_cnt == SC_LAST) begin
          sc_set = 1'b1;
          next_sc_state = rffs_pkg::RFFS_SC_TRIP;
        end
      end
      rffs_pkg::RFFS_SC_RUN: begin
        if (!sense_sync.phase0_en) begin
          next_sc_state = rffs_pkg::RFFS_SC_OFF;
        end else if (!sense_sync.phase0_above_short) begin
          sc_set = 1'b1;
          next_sc_state = rffs_pkg::RFFS_SC_TRIP;
        end
      end
      rffs_pkg::RFFS_SC_TRIP: begin
        // one report per enable; a re-enable rearms the supervision
        if (!sense_sync.phase0_en) begin
          next_sc_state = rffs_pkg::RFFS_SC_OFF;
        end
      end
      default: begin
        next_sc_state = rffs_pkg::RFFS_SC_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sc_state <= rffs_pkg::RFFS_SC_OFF;
      sc_cnt <= '0;
    end else begin
      sc_state <= next_sc_state;
      sc_cnt <= next_sc_cnt;
    end
  end

  // ******************************
  // sticky event flags
  // ******************************
  logic [7:0] ev01;
  logic [7:0] ev23;
  logic [7:0] next_ev01;
  logic [7:0] next_ev23;
  logic [7:0] set01;
  logic [7:0] set23;
  logic [7:0] clr01;
  logic [7:0] clr23;
  logic [3:0] ilim_rise;

  always_comb begin
    ilim_rise = sense_sync.ilim & ~sense_prev.ilim;
    set01 = 8'h00;
    set23 = 8'h00;
    set01[rffs_pkg::BIT_P0_OVERCURRENT] = ilim_rise[0];
    set01[rffs_pkg::BIT_P1_OVERCURRENT] = ilim_rise[1];
    set23[rffs_pkg::BIT_P2_OVERCURRENT] = ilim_rise[2];
    set23[rffs_pkg::BIT_P3_OVERCURRENT] = ilim_rise[3];
    set01[rffs_pkg::BIT_P0_POWERGOOD] =
      sense_sync.phase0_pg_above & ~sense_prev.phase0_pg_above;
    set01[rffs_pkg::BIT_P0_SHORT] = sc_set;
    // only ones clear; zeros leave a flag alone
    clr01 = (i_wr && i_addr == rffs_pkg::OFF_PHASE01_EVENT) ? i_wdata : 8'h00;
    clr23 = (i_wr && i_addr == rffs_pkg::OFF_PHASE23_EVENT) ? i_wdata : 8'h00;
    // a new event in the clearing cycle survives the clear
    next_ev01 = ((ev01 & ~clr01) | set01) & rffs_pkg::EVENT01_IMPL;
    next_ev23 = ((ev23 & ~clr23) | set23) & rffs_pkg::EVENT23_IMPL;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ev01 <= rffs_pkg::RST_EVENT;
      ev23 <= rffs_pkg::RST_EVENT;
    end else begin
      ev01 <= next_ev01;
      ev23 <= next_ev23;
    end
  end

  // ******************************
  // summary and interrupt
  // ******************************
  always_comb begin
    o_pending[0] = |ev01[rffs_pkg::BIT_P0_POWERGOOD:rffs_pkg::BIT_P0_OVERCURRENT];
    o_pending[1] = ev01[rffs_pkg::BIT_P1_OVERCURRENT];
    o_pending[2] = ev23[rffs_pkg::BIT_P2_OVERCURRENT];
    o_pending[3] = ev23[rffs_pkg::BIT_P3_OVERCURRENT];
    o_irq = |((ev01 & ~i_mask01) | (ev23 & ~i_mask23));
  end

  // ******************************
  // register read port
  // ******************************
  logic [7:0] live_thermal;
  logic [7:0] live01;
  logic [7:0] live23;
  logic [7:0] next_rdata;

  always_comb begin
    live_thermal = 8'h00;
    live01 = 8'h00;
    live23 = 8'h00;
    live_thermal[rffs_pkg::BIT_THERMAL_SHUTDOWN] = sense_sync.tdie_sd;
    live_thermal[rffs_pkg::BIT_THERMAL_WARNING] = sense_sync.tdie_warn;
    live01[rffs_pkg::BIT_P1_OVERCURRENT] = sense_sync.ilim[1];
    live01[rffs_pkg::BIT_P0_ENABLED] = sense_sync.phase0_en;
    live01[rffs_pkg::BIT_P0_POWERGOOD] = ~sense_sync.phase0_pg_above;
    live01[rffs_pkg::BIT_P0_OVERCURRENT] = sense_sync.ilim[0];
    live23[rffs_pkg::BIT_P3_OVERCURRENT] = sense_sync.ilim[3];
    live23[rffs_pkg::BIT_P2_OVERCURRENT] = sense_sync.ilim[2];
    case (i_addr)
      rffs_pkg::OFF_PHASE01_EVENT: next_rdata = ev01;
      rffs_pkg::OFF_PHASE23_EVENT: next_rdata = ev23;
      rffs_pkg::OFF_THERMAL_LIVE: next_rdata = live_thermal;
      rffs_pkg::OFF_PHASE01_LIVE: next_rdata = live01;
      rffs_pkg::OFF_PHASE23_LIVE: next_rdata = live23;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rdata <= rffs_pkg::RST_RDATA;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        o_rdata <= next_rdata;
      end
    end
  end

  // ******************************
  // assertions
  // ******************************
  a_ilim_latch: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(sense_sync.ilim[0]) |=> ev01[rffs_pkg::BIT_P0_OVERCURRENT])
    else $error("phase0 overcurrent edge not latched");

  a_w1c_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_wr && i_addr == rffs_pkg::OFF_PHASE23_EVENT && i_wdata[4] && !ilim_rise[3])
      |=> !ev23[rffs_pkg::BIT_P3_OVERCURRENT])
    else $error("phase3 overcurrent flag not cleared by one");

  a_pg_sticky: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ($rose(sense_sync.phase0_pg_above) ##1 (!(i_wr && i_addr == rffs_pkg::OFF_PHASE01_EVENT))[*3])
      |-> ev01[rffs_pkg::BIT_P0_POWERGOOD])
    else $error("power-good flag lost without clear");

  a_sc_drop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (sc_state == rffs_pkg::RFFS_SC_RUN && sense_sync.phase0_en
      && !sense_sync.phase0_above_short) |=> ev01[rffs_pkg::BIT_P0_SHORT]
      && sc_state == rffs_pkg::RFFS_SC_TRIP)
    else $error("short drop not flagged");

  a_sc_timeout: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (sc_state == rffs_pkg::RFFS_SC_START && sc_cnt < SC_LAST) |-> !sc_set)
    else $error("start timeout flagged early");

  a_thermal_live: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_rd && i_addr == rffs_pkg::OFF_THERMAL_LIVE) |=>
      o_rvalid && o_rdata == {4'h0, $past(sense_sync.tdie_sd), $past(sense_sync.tdie_warn), 2'h0})
    else $error("thermal status read wrong");

  a_phase01_live: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_rd && i_addr == rffs_pkg::OFF_PHASE01_LIVE) |=>
      o_rdata[2] != $past(sense_sync.phase0_pg_above) && o_rdata[7:5] == 3'h0)
    else $error("power-good live bit not inverted");

  a_pending_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (ev01 == 8'h00) |-> !o_pending[0] && !o_pending[1])
    else $error("pending bit stuck after clear");

  a_mask_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (((ev01 & ~i_mask01) | (ev23 & ~i_mask23)) == 8'h00) |-> !o_irq)
    else $error("masked event raised interrupt");

  // judged one edge after each reset edge, so the very first edge sees no unset flags
  a_reserved_zero: assert property (@(posedge i_clk_sys)
    i_rst |=> ev01 == rffs_pkg::RST_EVENT && ev23 == rffs_pkg::RST_EVENT && !o_rvalid)
    else $error("flags not zero after reset");

  c_ilim_event: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(ev23[rffs_pkg::BIT_P2_OVERCURRENT]));
  c_sc_timeout: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    sc_set && sc_state == rffs_pkg::RFFS_SC_START);
  c_set_on_clear: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    (clr01 & set01) != 8'h00);
  c_irq: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(o_irq));

endmodule

`default_nettype wire

// File: core/rffs_pkg.sv
/*
  Package for the regulator fault flag and status block: register offsets,
  field positions, reset values, the sensed-condition carrier and timing.
  Assumes an 8-bit register port driven by the serial interface engine.
*/
package rffs_pkg;

  // ******************************
  // register offsets
  // ******************************
  localparam logic [7:0] OFF_PHASE01_EVENT = 8'h19;
  localparam logic [7:0] OFF_PHASE23_EVENT = 8'h1A;
  localparam logic [7:0] OFF_THERMAL_LIVE = 8'h1B;
  localparam logic [7:0] OFF_PHASE01_LIVE = 8'h1C;
  localparam logic [7:0] OFF_PHASE23_LIVE = 8'h1D;

  // ******************************
  // field positions
  // ******************************
  localparam int unsigned BIT_P0_OVERCURRENT = 0;
  localparam int unsigned BIT_P0_SHORT = 1;
  localparam int unsigned BIT_P0_POWERGOOD = 2;
  localparam int unsigned BIT_P0_ENABLED = 3;
  localparam int unsigned BIT_P1_OVERCURRENT = 4;
  localparam int unsigned BIT_P2_OVERCURRENT = 0;
  localparam int unsigned BIT_P3_OVERCURRENT = 4;
  localparam int unsigned BIT_THERMAL_WARNING = 2;
  localparam int unsigned BIT_THERMAL_SHUTDOWN = 3;

  // writable (sticky) bits of each event register; all others read zero
  localparam logic [7:0] EVENT01_IMPL = 8'h17;
  localparam logic [7:0] EVENT23_IMPL = 8'h11;

  // ******************************
  // reset values
  // ******************************
  localparam logic [7:0] RST_EVENT = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // ******************************
  // timing
  // ******************************
  localparam int unsigned CLK_FREQ_MHZ = 200;
  localparam int unsigned SC_START_TIME_US = 1000;
  localparam int unsigned SC_START_CYCLES = SC_START_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned SC_CNT_W = 18;

  // ******************************
  // types
  // ******************************
  typedef struct packed {
    logic tdie_sd;
    logic tdie_warn;
    logic phase0_en;
    logic phase0_pg_above;
    logic phase0_above_short;
    logic [3:0] ilim;
  } rffs_sense_t;

  typedef enum logic [3:0] {
    RFFS_SC_OFF = 4'h1,
    RFFS_SC_START = 4'h2,
    RFFS_SC_RUN = 4'h4,
    RFFS_SC_TRIP = 4'h8
  } rffs_sc_state_t;

endpackage

// File: tb/rffs_plant.sv
/*
  Model of the regulator's analog side: turns requested conditions into
  sensed levels, launched just after each rising clock edge.
  Assumes the bench sets the request between edges.
*/
`timescale 1ns/1ps
`default_nettype none
module rffs_plant (
  input wire logic i_clk_sys,
  input wire rffs_pkg::rffs_sense_t i_req,
  output var rffs_pkg::rffs_sense_t o_sense
);
  // levels move only after an edge so the synchronisers see clean steps
  initial o_sense = '0;
  always @(posedge i_clk_sys) begin
    o_sense <= #1 i_req;
  end
endmodule
`default_nettype wire

// File: tb/test_regulator_fault_flag_status.sv
/*
  Self-checking bench for the fault flag and status block.
  Assumes the design's register strobe port and a short start timeout.
*/
`timescale 1ns/1ps
`default_nettype none
module test_regulator_fault_flag_status;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  rffs_pkg::rffs_sense_t req = '0;
  rffs_pkg::rffs_sense_t sense;
  logic [7:0] mask01 = 8'h00;
  logic [7:0] mask23 = 8'h00;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rvalid;
  logic [3:0] pending;
  logic irq;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  rffs_plant plant_u (.i_clk_sys(i_clk_sys), .i_req(req), .o_sense(sense));
  rffs_regulator_fault_flags #(.P_SC_START_CYCLES(20)) dut_u (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sense(sense), .i_mask01(mask01),
    .i_mask23(mask23), .i_addr(addr), .i_wr(wr), .i_wdata(wdata), .i_rd(rd),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_pending(pending), .o_irq(irq));
  // ******************************
  // helpers
  // ******************************
  task automatic complete_run();
    $display("counts: compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    // rvalid stands for one cycle only, so judge it here
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
    step(1);
  endtask
  function automatic logic [7:0] live(input logic [7:0] a, input rffs_pkg::rffs_sense_t s);
    case (a)
      8'h1B: live = {4'h0, s.tdie_sd, s.tdie_warn, 2'h0};
      8'h1C: live = {3'h0, s.ilim[1], s.phase0_en, ~s.phase0_pg_above, 1'b0, s.ilim[0]};
      default: live = {3'h0, s.ilim[3], 3'h0, s.ilim[2]};
    endcase
  endfunction
  // ******************************
  // scenarios
  // ******************************
  task automatic t_reset();
    logic [7:0] a;
    chk({4'h0, pending}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    for (int i = 0; i < 7; i++) begin
      a = (i < 5) ? 8'h19 + 8'(i) : 8'(i * 8'h0F);
      rchk(a, (i > 1 && i < 5) ? live(a, req) : 8'h00);
    end
    $display("test reset done");
  endtask
  task automatic t_live();
    logic [8:0] pats [4] = '{9'h1FF, 9'h0AA, 9'h155, 9'h000};
    for (int i = 0; i < 4; i++) begin
      req = rffs_pkg::rffs_sense_t'(pats[i]);
      step(4);
      wreg(8'h1B + 8'(i % 3), 8'hFF);
      rchk(8'h1B, live(8'h1B, req));
      rchk(8'h1C, live(8'h1C, req));
      rchk(8'h1D, live(8'h1D, req));
    end
    wreg(8'h19, 8'hFF);
    wreg(8'h1A, 8'hFF);
    $display("test live done");
  endtask
  task automatic t_events();
    req.ilim = 4'hF;
    req.phase0_pg_above = 1'b1;
    req.phase0_above_short = 1'b1;
    step(4);
    rchk(8'h19, 8'h15);
    rchk(8'h1A, 8'h11);
    chk({4'h0, pending}, 8'h0F);
    chk({7'h00, irq}, 8'h01);
    wreg(8'h19, 8'h00);
    rchk(8'h19, 8'h15);
    wreg(8'h19, 8'h01);
    rchk(8'h19, 8'h14);
    chk({4'h0, pending}, 8'h0F);
    wreg(8'h19, 8'h14);
    chk({4'h0, pending}, 8'h0C);
    wreg(8'h1A, 8'h10);
    chk({4'h0, pending}, 8'h04);
    wreg(8'h1A, 8'h01);
    chk({4'h0, pending}, 8'h00);
    rchk(8'h19, 8'h00);
    $display("test events done");
  endtask
  task automatic t_mask();
    mask01 = 8'hFF;
    mask23 = 8'hFF;
    req.ilim = 4'h0;
    step(4);
    req.ilim[2] = 1'b1;
    req.ilim[1] = 1'b1;
    step(4);
    chk({4'h0, pending}, 8'h06);
    chk({7'h00, irq}, 8'h00);
    rchk(8'h1D, 8'h01);
    rchk(8'h1C, 8'h10);
    mask23 = 8'h00;
    step(1);
    chk({7'h00, irq}, 8'h01);
    mask23 = 8'hFF;
    mask01 = 8'h00;
    step(1);
    chk({7'h00, irq}, 8'h01);
    wreg(8'h19, 8'h10);
    chk({7'h00, irq}, 8'h00);
    mask23 = 8'h00;
    step(1);
    chk({7'h00, irq}, 8'h01);
    wreg(8'h1A, 8'h01);
    chk({7'h00, irq}, 8'h00);
    $display("test mask done");
  endtask
  task automatic t_short();
    req = '0;
    step(4);
    wreg(8'h19, 8'hFF);
    req.phase0_en = 1'b1;
    step(30);
    rchk(8'h19, 8'h02);
    wreg(8'h19, 8'h02);
    req.phase0_en = 1'b0;
    step(4);
    req.phase0_en = 1'b1;
    req.phase0_above_short = 1'b1;
    step(30);
    rchk(8'h19, 8'h00);
    req.phase0_above_short = 1'b0;
    step(5);
    rchk(8'h19, 8'h02);
    $display("test short done");
  endtask
  initial begin
    step(8);
    i_rst = 1'b0;
    t_reset();
    t_live();
    t_events();
    t_mask();
    t_short();
    complete_run();
  end
endmodule
`default_nettype wire
